// [hdl/tsma_core.sv]
// tsma_core: host view of connection, message, monitor and error-enable memories plus error counters
// assumes word accesses on a plain strobe bus and per-group rates from the group control logic
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns

// Contract
// - 65M rate: ten bits select channel
// - 32M rate: bits 9-1 channel, bit0 stream
// - 16M rate: bits 9-2 channel, 1-0 stream
// - 8M rate: bits 9-3 channel; host bit2 zero
// - message mode sends low byte msb first
// - packed view of message bytes, four per word
// - packed bytes big-endian, lowest channel on top
// - packed windows 1KiB per group from 20000
// - packed window split by rate, 8M upper errors
// - monitor memory read-only, write gives bus error
// - monitor windows 1KiB per group from 28000
// - time-slot k at byte offset k
// - monitor window split by input rate
// - enable memory bytes, 1KiB groups from 30000
// - enable bit zero gates counting per slot
// - 96 counters, upper half reads zero
// - any write to counter clears it
// - count single-bit errors since last clear
// - counter saturates at 65535
// - connection word is four bytes per slot
// - function code 010 selects message mode
module tsma_core
    import tsma_pkg::*;
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    // host register bus
    input  wire logic [18:0]               i_addr,
    input  wire logic [31:0]               i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [31:0]               o_rdata,
    output logic                           o_bus_error_n,
    // group rates
    input  wire logic [23:0][1:0]          i_out_rate,
    input  wire logic [23:0][1:0]          i_in_rate,
    // output slot lookup
    input  wire logic                      i_out_vld,
    input  wire tsma_slot_s                i_out_slot,
    output logic                           o_src_vld,
    output tsma_src_s                      o_src,
    // message serial
    input  wire logic                      i_bit_tick,
    output logic                           o_msg_bit,
    // received slots
    input  wire logic                      i_rx_vld,
    input  wire tsma_rx_s                  i_rx
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [31:0] cm_mem [0:MEM_DEPTH-1];
    logic [7:0]  dm_mem [0:MEM_DEPTH-1];
    logic [7:0]  en_mem [0:MEM_DEPTH-1];
    logic [15:0] cnt_r  [0:NUM_CNT-1];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic [18:0] lsb_off;
    logic [18:0] dm_off;
    logic [18:0] en_off;
    logic [18:0] bc_off;
    logic        in_cm;
    logic        in_lsb;
    logic        in_dm;
    logic        in_en;
    logic        in_bc;
    logic [4:0]  cm_grp;
    logic [4:0]  lsb_grp;
    logic [4:0]  dm_grp;
    logic [4:0]  en_grp;
    logic [4:0]  bc_grp;
    logic [1:0]  bc_st;
    logic [6:0]  clr_idx;
    logic        cm_ok;
    logic        lsb_ok;
    logic        dm_ok;
    logic        bc_ok;
    logic        acc_ok;
    logic        acc;

    assign acc     = i_wr | i_rd;
    assign lsb_off = i_addr - LSB_BASE;
    assign dm_off  = i_addr - DM_BASE;
    assign en_off  = i_addr - EN_BASE;
    assign bc_off  = i_addr - BC_BASE;

    assign in_cm   = i_addr <= CM_END;
    assign in_lsb  = (i_addr >= LSB_BASE) && (i_addr <= LSB_END);
    assign in_dm   = (i_addr >= DM_BASE) && (i_addr <= DM_END);
    assign in_en   = (i_addr >= EN_BASE) && (i_addr <= EN_END);
    assign in_bc   = (i_addr >= BC_BASE) && (i_addr <= BC_END);

    assign cm_grp  = i_addr[16:12];
    assign lsb_grp = lsb_off[14:10];
    assign dm_grp  = dm_off[14:10];
    assign en_grp  = en_off[14:10];
    assign bc_st   = bc_off[8:7];
    assign bc_grp  = bc_off[6:2];
    // counters are stream-major, 24 used words per stream
    assign clr_idx = 7'({bc_st, 5'h00} - {2'h0, bc_st, 3'h0}) + 7'(bc_grp);

    // ----------------------------------------
    // legality per region
    // ----------------------------------------
    assign cm_ok   = tsma_off_ok(i_out_rate[cm_grp], i_addr[11:2]);
    assign lsb_ok  = tsma_off_ok(i_out_rate[lsb_grp], lsb_off[9:0]);
    assign dm_ok   = !i_wr && tsma_off_ok(i_in_rate[dm_grp], dm_off[9:0]);
    assign bc_ok   = bc_grp < NUM_GRP;
    assign acc_ok  = (in_cm && cm_ok) || (in_lsb && lsb_ok) || (in_dm && dm_ok) ||
                     in_en || (in_bc && bc_ok);

    // ----------------------------------------
    // word indices
    // ----------------------------------------
    logic [14:0] cm_idx;
    logic [14:0] lsb_idx;
    logic [14:0] dm_idx;
    logic [14:0] en_idx;
    logic        cm_wr;
    logic        lsb_wr;
    logic        en_wr;
    logic        bc_clr;

    assign cm_idx  = {cm_grp, i_addr[11:2]};
    assign lsb_idx = {lsb_grp, lsb_off[9:2], 2'b00};
    assign dm_idx  = {dm_grp, dm_off[9:2], 2'b00};
    assign en_idx  = {en_grp, en_off[9:2], 2'b00};
    assign cm_wr   = i_wr && in_cm && cm_ok;
    assign lsb_wr  = i_wr && in_lsb && lsb_ok;
    assign en_wr   = i_wr && in_en;
    assign bc_clr  = i_wr && in_bc && bc_ok;

    // ----------------------------------------
    // read data select
    // ----------------------------------------
    logic [31:0] lsb_word;
    logic [31:0] dm_word;
    logic [31:0] en_word;
    logic [31:0] rd_word;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic        bus_error_n_n_r;

    // lowest channel on the top byte lane
    assign lsb_word  = {cm_mem[lsb_idx][7:0], cm_mem[lsb_idx + 15'h1][7:0],
                        cm_mem[lsb_idx + 15'h2][7:0], cm_mem[lsb_idx + 15'h3][7:0]};
    assign dm_word   = {dm_mem[dm_idx], dm_mem[dm_idx + 15'h1],
                        dm_mem[dm_idx + 15'h2], dm_mem[dm_idx + 15'h3]};
    assign en_word   = {en_mem[en_idx], en_mem[en_idx + 15'h1],
                        en_mem[en_idx + 15'h2], en_mem[en_idx + 15'h3]};
    assign rd_word   = in_cm  ? cm_mem[cm_idx] :
                       in_lsb ? lsb_word :
                       in_dm  ? dm_word :
                       in_en  ? en_word :
                                {16'h0000, cnt_r[clr_idx]};
    assign rdata_nxt = (i_rd && acc_ok) ? rd_word : RDATA_RST;
    assign o_rdata       = rdata_r;
    assign o_bus_error_n = bus_error_n_n_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r  <= RDATA_RST;
            bus_error_n_n_r <= 1'b1;
        end else begin
            rdata_r  <= rdata_nxt;
            bus_error_n_n_r <= !(acc && !acc_ok);
        end
    end

    // ----------------------------------------
    // host and receive writes into memories
    // ----------------------------------------
    logic [14:0] rx_idx;

    assign rx_idx = {i_rx.grp, tsma_slot_off(i_in_rate[i_rx.grp], i_rx.stream, i_rx.slot)};

    always_ff @(posedge i_clk) begin
        if (cm_wr) begin
            cm_mem[cm_idx] <= i_wdata;
        end
        for (int k = 0; k < 4; k++) begin
            if (lsb_wr) begin
                cm_mem[lsb_idx + 15'(k)][7:0] <= i_wdata[31 - 8 * k -: 8];
            end
            if (en_wr) begin
                en_mem[en_idx + 15'(k)] <= i_wdata[31 - 8 * k -: 8];
            end
        end
        if (i_rx_vld) begin
            dm_mem[rx_idx] <= i_rx.data;
        end
    end

    // ----------------------------------------
    // error counters
    // ----------------------------------------
    logic [6:0]  inc_idx;
    logic        inc_hit;
    logic [15:0] cnt_sel;

    assign inc_idx = 7'({i_rx.stream, 5'h00} - {2'h0, i_rx.stream, 3'h0}) + 7'(i_rx.grp);
    assign inc_hit = i_rx_vld && i_rx.bit_err && en_mem[rx_idx][0];
    assign cnt_sel = cnt_r[inc_idx];

    // an error in the clearing cycle is kept as a count of one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int c = 0; c < NUM_CNT; c++) begin
                cnt_r[c] <= CNT_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CNT; c++) begin
                if (inc_hit && (inc_idx == 7'(c))) begin
                    if (bc_clr && (clr_idx == 7'(c))) begin
                        cnt_r[c] <= 16'h0001;
                    end else if (cnt_r[c] != CNT_MAX) begin
                        cnt_r[c] <= cnt_r[c] + 16'h0001;
                    end
                end else if (bc_clr && (clr_idx == 7'(c))) begin
                    cnt_r[c] <= CNT_RST;
                end
            end
        end
    end

    // ----------------------------------------
    // output slot source decode
    // ----------------------------------------
    logic [31:0] out_word;
    logic [1:0]  out_rate;
    logic [9:0]  source_channel_select;
    tsma_src_s   src_nxt;
    tsma_src_s   src_r;
    logic        src_vld_r;

    assign out_rate = i_out_rate[i_out_slot.grp];
    assign out_word = cm_mem[{i_out_slot.grp,
                              tsma_slot_off(out_rate, i_out_slot.stream, i_out_slot.slot)}];
    assign source_channel_select     = out_word[9:0];

    always_comb begin
        src_nxt          = '0;
        src_nxt.per_channel_function      = out_word[31:29];
        src_nxt.msg      = out_word[31:29] == PCF_MSG;
        src_nxt.grp      = out_word[14:10];
        src_nxt.msg_byte = out_word[7:0];
        case (out_rate)
            RATE_65: begin
                src_nxt.chan   = source_channel_select;
                src_nxt.stream = 2'h0;
            end
            RATE_32: begin
                src_nxt.chan   = {1'b0, source_channel_select[9:1]};
                src_nxt.stream = {1'b0, source_channel_select[0]};
            end
            RATE_16: begin
                src_nxt.chan   = {2'b00, source_channel_select[9:2]};
                src_nxt.stream = source_channel_select[1:0];
            end
            default: begin
                src_nxt.chan   = {3'b000, source_channel_select[9:3]};
                src_nxt.stream = source_channel_select[1:0];
            end
        endcase
    end

    assign o_src     = src_r;
    assign o_src_vld = src_vld_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_r     <= '0;
            src_vld_r <= 1'b0;
        end else begin
            src_vld_r <= i_out_vld;
            if (i_out_vld) begin
                src_r <= src_nxt;
            end
        end
    end

    tsma_msg_ser u_msg_ser (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_load  (i_out_vld && src_nxt.msg),
        .i_byte  (src_nxt.msg_byte),
        .i_shift (i_bit_tick),
        .o_bit   (o_msg_bit)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_dm_write_err : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_wr && in_dm) |=> !o_bus_error_n)
        else $error("monitor write not refused");

    chk_lsb8_err : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (acc && in_lsb && (i_out_rate[lsb_grp] == RATE_8) && lsb_off[9]) |=> !o_bus_error_n)
        else $error("packed upper half at 8M not refused");

    chk_cnt_upper_zero : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rd && in_bc) |=> (o_rdata[31:16] == 16'h0000))
        else $error("counter upper half not zero");

    chk_cnt_clear : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (bc_clr && !(inc_hit && (inc_idx == clr_idx))) |=> (cnt_r[$past(clr_idx)] == CNT_RST))
        else $error("counter not cleared by write");

    chk_cnt_count : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (inc_hit && !bc_clr && (cnt_sel != CNT_MAX)) |=> (cnt_r[$past(inc_idx)] == $past(cnt_sel) + 16'h1))
        else $error("counter missed an error");

    chk_cnt_saturate : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (inc_hit && !bc_clr && (cnt_sel == CNT_MAX)) |=> (cnt_r[$past(inc_idx)] == CNT_MAX))
        else $error("counter wrapped");

    chk_cnt_gated : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_vld && !en_mem[rx_idx][0] && !bc_clr) |=> (cnt_r[$past(inc_idx)] == $past(cnt_sel)))
        else $error("counter moved in disabled slot");

    chk_src_65 : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_out_vld && (out_rate == RATE_65)) |=> (o_src_vld && (o_src.chan == $past(source_channel_select))))
        else $error("65M channel decode wrong");

    chk_src_16 : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_out_vld && (out_rate == RATE_16)) |=> (o_src.stream == $past(source_channel_select[1:0])))
        else $error("16M stream decode wrong");

endmodule : tsma_core

// [hdl/tsma_msg_ser.sv]
// tsma_msg_ser: shifts a message byte out one bit per tick, msb first
// assumes the caller pulses the tick once per output bit time
`timescale 1ns/1ns
module tsma_msg_ser
    import tsma_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // control
    input  wire logic       i_load,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_shift,
    // serial out
    output logic            o_bit
);

    logic [7:0] shift_r;
    logic [7:0] shift_nxt;

    // load wins over shift; zeros fill behind
    assign shift_nxt = i_load  ? i_byte :
                       i_shift ? {shift_r[6:0], 1'b0} : shift_r;
    assign o_bit     = shift_r[7];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_r <= 8'h00;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    chk_msg_first_bit : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_load |=> (o_bit == $past(i_byte[7])))
        else $error("message msb not sent first");

    chk_msg_second_bit : assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_load ##1 (i_shift && !i_load)) |=> (o_bit == $past(i_byte[6], 2)))
        else $error("message bit order wrong");

endmodule : tsma_msg_ser

// [include/tsma_pkg.sv]
// tsma_pkg: map, encodings, carriers and decode helpers for the tdm switch memory access block
// assumes a 19-bit byte address and group rates from the group control logic outside
package tsma_pkg;

    // ----------------------------------------
    // address map
    // ----------------------------------------
    localparam logic [18:0] CM_END    = 19'h17FFF;
    localparam logic [18:0] LSB_BASE  = 19'h20000;
    localparam logic [18:0] LSB_END   = 19'h25FFF;
    localparam logic [18:0] DM_BASE   = 19'h28000;
    localparam logic [18:0] DM_END    = 19'h2DFFF;
    localparam logic [18:0] EN_BASE   = 19'h30000;
    localparam logic [18:0] EN_END    = 19'h35FFF;
    localparam logic [18:0] BC_BASE   = 19'h40000;
    localparam logic [18:0] BC_END    = 19'h401FF;
    localparam logic [9:0]  OFF8_LIM  = 10'h200;
    localparam logic [4:0]  NUM_GRP   = 5'h18;
    localparam int          MEM_DEPTH = 24576;
    localparam int          NUM_CNT   = 96;

    // ----------------------------------------
    // field values and reset values
    // ----------------------------------------
    localparam logic [1:0]  RATE_8    = 2'h0;
    localparam logic [1:0]  RATE_16   = 2'h1;
    localparam logic [1:0]  RATE_32   = 2'h2;
    localparam logic [1:0]  RATE_65   = 2'h3;
    localparam logic [2:0]  PCF_MSG   = 3'h2;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] grp;
        logic [1:0] stream;
        logic [9:0] slot;
    } tsma_slot_s;

    typedef struct packed {
        logic [4:0] grp;
        logic [1:0] stream;
        logic [9:0] slot;
        logic [7:0] data;
        logic       bit_err;
    } tsma_rx_s;

    typedef struct packed {
        logic       msg;
        logic [2:0] per_channel_function;
        logic [4:0] grp;
        logic [9:0] chan;
        logic [1:0] stream;
        logic [7:0] msg_byte;
    } tsma_src_s;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [9:0] tsma_slot_off(input logic [1:0] rate, input logic [1:0] st,
                                                 input logic [9:0] slot);
        case (rate)
            RATE_65: tsma_slot_off = slot;
            RATE_32: tsma_slot_off = {st[0], slot[8:0]};
            RATE_16: tsma_slot_off = {st, slot[7:0]};
            default: tsma_slot_off = {1'b0, st, slot[6:0]};
        endcase
    endfunction : tsma_slot_off

    function automatic logic tsma_off_ok(input logic [1:0] rate, input logic [9:0] off);
        tsma_off_ok = (rate != RATE_8) || (off < OFF8_LIM);
    endfunction : tsma_off_ok

endpackage : tsma_pkg

// [verification/test_tdm_switch_memory_access.sv]
// test_tdm_switch_memory_access: self-checking bench for tsma_core
// assumes tsma_host_model as bus master, stream side driven here
`timescale 1ns/1ns
module test_tdm_switch_memory_access
    import tsma_pkg::*;
;
    logic             i_clk;
    logic             i_rst_b;
    logic [18:0]      addr;
    logic [31:0]      wdata;
    logic             wr;
    logic             rd;
    logic [31:0]      rdata;
    logic             bus_error_n;
    logic [23:0][1:0] out_rate;
    logic [23:0][1:0] in_rate;
    logic             out_vld;
    tsma_slot_s       out_slot;
    logic             src_vld;
    tsma_src_s        src;
    logic             bit_tick;
    logic             msg_bit;
    logic             rx_vld;
    tsma_rx_s         rx;
    int               mismatches;
    int               cmp_count;
    logic [31:0]      rv;
    logic             en;

    tsma_host_model u_host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
                            .i_rdata(rdata), .i_bus_error_n(bus_error_n));

    tsma_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
                   .i_rd(rd), .o_rdata(rdata), .o_bus_error_n(bus_error_n), .i_out_rate(out_rate),
                   .i_in_rate(in_rate), .i_out_vld(out_vld), .i_out_slot(out_slot), .o_src_vld(src_vld),
                   .o_src(src), .i_bit_tick(bit_tick), .o_msg_bit(msg_bit), .i_rx_vld(rx_vld), .i_rx(rx));

    initial i_clk = 1'h0;
    always #10 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // outputs in the first cycle after reset release
    task automatic test_reset();
        chk(rdata, RDATA_RST, "reset read data");
        chk({29'h0000_0000, bus_error_n, src_vld, msg_bit}, 32'h0000_0004, "reset flags");
        $display("test reset done");
    endtask : test_reset

    task automatic lookup(input logic [4:0] g, input logic [1:0] s, input logic [9:0] sl);
        @(posedge i_clk);
        out_vld  <= 1'h1;
        out_slot <= '{grp: g, stream: s, slot: sl};
        @(posedge i_clk);
        out_vld  <= 1'h0;
        #1;
        chk(src_vld, 1'h1, "lookup answer");
    endtask : lookup

    task automatic rxs(input logic [4:0] g, input logic [1:0] s, input logic [9:0] sl, input logic [7:0] d,
                       input logic e);
        @(posedge i_clk);
        rx_vld <= 1'h1;
        rx     <= '{grp: g, stream: s, slot: sl, data: d, bit_err: e};
        @(posedge i_clk);
        rx_vld <= 1'h0;
    endtask : rxs

    // rate-dependent source field decode, stream b slot 3 (stream a at 65M)
    task automatic test_conn();
        logic [9:0] off [4];
        logic [9:0] chn [4];
        off = '{10'h083, 10'h103, 10'h203, 10'h003};
        chn = '{10'h055, 10'h0AA, 10'h154, 10'h2A9};
        for (int r = 0; r < 4; r++) begin
            out_rate[5] <= r[1:0];
            u_host.wr(19'h05000 + {7'h00, off[r], 2'h0}, 32'h8000_46A9, en);
            lookup(5'h05, (r == 3) ? 2'h0 : 2'h1, 10'h003);
            chk(src.chan, chn[r], "channel");
            chk(src.stream, (r == 3) ? 2'h0 : 2'h1, "stream");
            chk(src.grp, 5'h11, "group");
            chk(src.per_channel_function, 3'h4, "function code");
            chk(src.msg, 1'h0, "not message");
        end
        $display("test conn done");
    endtask : test_conn

    // message mode, serial order, packed bytes and rate split
    task automatic test_msg();
        out_rate[2] <= RATE_65;
        u_host.wr(19'h02020, 32'h4000_00C5, en);
        u_host.wr(19'h02024, 32'h4000_0000, en);
        lookup(5'h02, 2'h0, 10'h008);
        chk(src.msg, 1'h1, "message mode");
        chk(src.msg_byte, 8'hC5, "message byte");
        chk(msg_bit, 1'h1, "first bit");
        for (int i = 6; i >= 0; i--) begin
            bit_tick <= 1'h1;
            @(posedge i_clk);
            #1;
            chk(msg_bit, 1'(8'hC5 >> i), "serial bit");
        end
        bit_tick <= 1'h0;
        u_host.wr(19'h20808, 32'h1122_3344, en);
        chk(en, 1'h1, "packed write");
        u_host.rd(19'h02020, rv, en);
        chk(rv, 32'h4000_0011, "packed top byte");
        lookup(5'h02, 2'h0, 10'h009);
        chk(src.msg_byte, 8'h22, "packed second byte");
        u_host.rd(19'h20808, rv, en);
        chk(rv, 32'h1122_3344, "packed read");
        out_rate[2] <= RATE_8;
        u_host.wr(19'h20A00, 32'h0000_0000, en);
        chk(en, 1'h0, "upper half at 8M");
        u_host.wr(19'h02200, 32'h4000_0000, en);
        u_host.wr(19'h20880, 32'h5500_0000, en);
        lookup(5'h02, 2'h1, 10'h000);
        chk(src.msg_byte, 8'h55, "stream b at 8M");
        chk(src.msg, 1'h1, "message at 8M");
        u_host.rd(19'h18000, rv, en);
        chk(en, 1'h0, "unmapped read error");
        chk(rv, 32'h0000_0000, "unmapped read data");
        $display("test msg done");
    endtask : test_msg

    // monitor memory placement and write refusal
    task automatic test_mon();
        in_rate[3] <= RATE_16;
        rxs(5'h03, 2'h2, 10'h005, 8'h5A, 1'h0);
        u_host.rd(19'h28E04, rv, en);
        chk(rv[23:16], 8'h5A, "monitor byte");
        u_host.wr(19'h28E04, 32'h0000_0000, en);
        chk(en, 1'h0, "monitor write");
        u_host.rd(19'h28E04, rv, en);
        chk(rv[23:16], 8'h5A, "monitor kept");
        $display("test mon done");
    endtask : test_mon

    // enable gating, counting, clear and saturation
    task automatic test_ber();
        in_rate[4] <= RATE_65;
        u_host.wr(19'h31004, 32'h0000_0100, en);
        u_host.rd(19'h31004, rv, en);
        chk(rv, 32'h0000_0100, "enable bytes");
        u_host.wr(19'h40010, 32'h0000_0000, en);
        for (int i = 0; i < 3; i++) rxs(5'h04, 2'h0, 10'h006, 8'h00, 1'h1);
        for (int i = 0; i < 2; i++) rxs(5'h04, 2'h0, 10'h007, 8'h00, 1'h1);
        rxs(5'h04, 2'h0, 10'h006, 8'h00, 1'h0);
        u_host.rd(19'h40010, rv, en);
        chk(rv, 32'h0000_0003, "error count");
        u_host.wr(19'h40010, 32'hFFFF_0000, en);
        u_host.rd(19'h40010, rv, en);
        chk(rv, 32'h0000_0000, "cleared");
        @(posedge i_clk);
        rx_vld <= 1'h1;
        rx     <= '{grp: 5'h04, stream: 2'h0, slot: 10'h006, data: 8'h00, bit_err: 1'h1};
        repeat (65537) @(posedge i_clk);
        rx_vld <= 1'h0;
        u_host.rd(19'h40010, rv, en);
        chk(rv, 32'h0000_FFFF, "saturated");
        $display("test ber done");
    endtask : test_ber

    initial begin
        i_rst_b = 1'h0;
        out_rate = '0;
        in_rate = '0;
        out_vld = 1'h0;
        out_slot = '0;
        bit_tick = 1'h0;
        rx_vld = 1'h0;
        rx = '0;
        rv = 32'h0000_0000;
        mismatches = 0;
        cmp_count = 0;
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'h1;
        #1;
        test_reset();
        test_conn();
        test_msg();
        test_mon();
        test_ber();
        complete_run();
    end

    // watchdog well past the saturation run
    initial begin
        #1_600_000;
        mismatches++;
        complete_run();
    end
endmodule : test_tdm_switch_memory_access

// [verification/tsma_host_model.sv]
// tsma_host_model: host processor on the plain strobe bus
// assumes the block answers in the cycle after each strobe
`timescale 1ns/1ns
module tsma_host_model (
    // clock
    input  wire logic        i_clk,
    // bus out
    output logic      [18:0] o_addr,
    output logic      [31:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    // bus in
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_bus_error_n
);
    initial begin
        o_addr = 19'h00000;
        o_wdata = 32'h0000_0000;
        o_wr = 1'h0;
        o_rd = 1'h0;
    end

    // callers keep unused and rate-reserved bits zero, except the counter clear in test_ber, which sets the unused upper half
    task automatic wr(input logic [18:0] a, input logic [31:0] d, output logic err_n);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'h1;
        @(posedge i_clk);
        o_wr    <= 1'h0;
        o_addr  <= ~a;
        o_wdata <= ~d;
        #1;
        err_n = i_bus_error_n;
    endtask : wr

    task automatic rd(input logic [18:0] a, output logic [31:0] d, output logic err_n);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'h1;
        @(posedge i_clk);
        o_rd   <= 1'h0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
        err_n = i_bus_error_n;
    endtask : rd
endmodule : tsma_host_model
